// [common/sslk_pkg.sv]
// ****************************************************************
// Servo sync lock constants
// ****************************************************************
package sslk_pkg;

	// Avalon-MM register map (byte addresses)
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_PHASE = 5'h10;
	localparam logic [ADDR_W-1:0] REG_TRACK = 5'h14;

	// Control register fields
	localparam int CTRL_OVR_EN = 0;
	localparam int CTRL_SEL_LO = 1;
	localparam int CTRL_SEL_HI = 2;
	localparam int CTRL_TRK_EN = 3;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h8;

	// Status register fields
	localparam int STAT_LOCK = 0;
	localparam int STAT_WIDE = 1;
	localparam int STAT_SEL_LO = 4;
	localparam int STAT_FIELD_LO = 8;

	// Interrupt status and mask bits
	localparam int IRQ_W = 4;
	localparam int IRQ_LOCK_GAIN = 0;
	localparam int IRQ_LOCK_LOST = 1;
	localparam int IRQ_DROP = 2;
	localparam int IRQ_REALIGN = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

	// Frame timing: a field is 32 counts, each count 1 to 4 clocks
	localparam int SEL_W = 2;
	localparam int FIELD_W = 5;
	localparam int FRAME_W = SEL_W + FIELD_W;
	localparam logic [FIELD_W-1:0] FIELD_MAX = 5'h1F;
	localparam logic [FIELD_W-1:0] WIN_LEN = 5'h02;
	localparam logic [FIELD_W-1:0] WIDE_COUNTS = 5'h06;
	localparam logic [FIELD_W-1:0] HALF_FIELD = 5'h10;

	// Lock evaluator run length
	localparam int RUN_W = 3;
	localparam logic [RUN_W-1:0] LOCK_RUN = 3'h4;

	// Phase error, track history and sample-hold widths
	localparam int PH_W = 8;
	localparam int TRK_HIST_W = 8;
	localparam int SH_CH = 2;

endpackage

// [hw/sslk_core.sv]
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module sslk_core (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic frame_ratio_sel_lo_in,
	input wire logic frame_ratio_sel_hi_in,
	input wire logic sync_pulse_in,
	input wire logic [sslk_pkg::SH_CH-1:0] peak_done_in,
	input wire logic [sslk_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [sslk_pkg::DATA_W-1:0] avs_writedata_in,
	output logic [sslk_pkg::DATA_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out,
	output logic lock_out,
	output logic aperture_wide_out,
	output logic sync_gate_out,
	output logic phase_valid_out,
	output logic [sslk_pkg::PH_W-1:0] phase_err_out,
	output logic track_bit_clock_out,
	output logic track_bit_out,
	output logic [sslk_pkg::SH_CH-1:0] sh_release_out
);
	import sslk_pkg::*;

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic [1:0] rst_pipe;
	logic rst_n;

	// Assert at once, release two clocks later so all flops leave reset together
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [CTRL_W-1:0] ctrl;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_ev;
	logic [TRK_HIST_W-1:0] trk_hist;
	logic [SEL_W-1:0] ratio_sel;
	logic [SEL_W-1:0] sub_cnt;
	logic [FIELD_W-1:0] field_cnt;
	logic [FRAME_W-1:0] frame_cnt;
	logic [FRAME_W-1:0] frame_last;
	logic frame_wrap;
	logic sync_q;
	logic sync_rise;
	logic in_norm;
	logic in_wide;
	logic in_aper;
	logic realign;
	logic lock;
	logic wide;
	logic wide_eff;
	logic seen;
	logic dropped;
	logic [RUN_W-1:0] in_run;
	logic [RUN_W-1:0] out_run;
	logic lock_set;
	logic lock_clr;
	logic [PH_W-1:0] next_phase;
	logic bus_req;
	logic bus_ack;
	logic wr_en;
	logic [DATA_W-1:0] rd_mux;

	// ****************************************************************
	// Frame timing
	// ****************************************************************

	// Software may take the ratio over from the pins
	assign ratio_sel = ctrl[CTRL_OVR_EN] ? ctrl[CTRL_SEL_HI:CTRL_SEL_LO]
		: {frame_ratio_sel_hi_in, frame_ratio_sel_lo_in};
	// Last count of a frame is (sel+1)*32-1
	assign frame_last = {ratio_sel, FIELD_MAX};
	assign frame_wrap = (frame_cnt == frame_last);

	// Frame counter and field counter restart together; the field counter is
	// the 32-count scale, so every ratio sees the same window geometry
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			frame_cnt <= '0;
			sub_cnt <= '0;
			field_cnt <= '0;
		end else if (realign) begin
			// The pulse's own cycle is count zero, so the next clock is the second
			// of the frame; loading zero here would bring every later pulse one
			// clock ahead of the window and realign again for ever
			frame_cnt <= 7'h01;
			sub_cnt <= (ratio_sel == 2'h0) ? 2'h0 : 2'h1;
			field_cnt <= (ratio_sel == 2'h0) ? 5'h01 : 5'h00;
		end else begin
			frame_cnt <= frame_wrap ? '0 : frame_cnt + 7'h01;
			if (frame_wrap || sub_cnt >= ratio_sel) begin
				sub_cnt <= '0;
				field_cnt <= frame_wrap ? '0 : field_cnt + 5'h01;
			end else begin
				sub_cnt <= sub_cnt + 2'h1;
			end
		end
	end

	// ****************************************************************
	// Sync edge and windows
	// ****************************************************************

	// Pin is synchronous to the clock; only the rising edge marks arrival
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= 1'b0;
		end else begin
			sync_q <= sync_pulse_in;
		end
	end
	assign sync_rise = sync_pulse_in & ~sync_q;

	// Normal window is counts 0 and 1; the wide one spans the tuning range
	assign in_norm = (field_cnt < WIN_LEN);
	assign in_wide = (field_cnt < WIN_LEN + WIDE_COUNTS) || (field_cnt >= 5'h00 - WIDE_COUNTS);
	assign wide_eff = wide & ~lock;
	assign in_aper = in_norm | (wide_eff & in_wide);
	assign realign = sync_rise & ~lock & ~in_norm;

	// Wide aperture: on after reset, re-armed by each realign, off at lock
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wide <= 1'b1;
		end else if (realign) begin
			wide <= 1'b1;
		end else if (lock_set) begin
			wide <= 1'b0;
		end
	end

	// Gate latches open on an aperture hit; held until sync returns low so the
	// trailing edge is never clipped
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sync_gate_out <= 1'b0;
		end else if (!sync_pulse_in) begin
			sync_gate_out <= 1'b0;
		end else if (sync_rise && in_aper) begin
			sync_gate_out <= 1'b1;
		end
	end

	// ****************************************************************
	// Phase comparison
	// ****************************************************************

	// Error is the arrival offset from frame start, negative in the late half
	always_comb begin
		next_phase = {1'b0, frame_cnt};
		if (field_cnt >= HALF_FIELD) begin
			next_phase = {1'b0, frame_cnt} - {1'b0, frame_last} - 8'h01;
		end
	end

	// Fires only on an arriving pulse in the aperture, so a dropped sync gives
	// nothing and stray pulses while locked are ignored
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			phase_valid_out <= 1'b0;
			phase_err_out <= '0;
		end else begin
			phase_valid_out <= sync_rise & in_aper;
			if (sync_rise && in_aper) begin
				phase_err_out <= next_phase;
			end
		end
	end

	// ****************************************************************
	// Lock evaluator
	// ****************************************************************
	assign lock_set = sync_rise & in_norm & (in_run == LOCK_RUN - 3'h1);
	assign lock_clr = sync_rise & ~in_norm & (out_run == LOCK_RUN - 3'h1);

	// Runs move only on a present pulse; a missing sync leaves them alone
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			in_run <= '0;
			out_run <= '0;
		end else if (sync_rise) begin
			if (in_norm) begin
				in_run <= (in_run == LOCK_RUN) ? in_run : in_run + 3'h1;
				out_run <= '0;
			end else begin
				out_run <= (out_run == LOCK_RUN) ? out_run : out_run + 3'h1;
				in_run <= '0;
			end
		end
	end

	// Lock indicator holds unless a full run of four agrees
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			lock <= 1'b0;
		end else if (lock_set) begin
			lock <= 1'b1;
		end else if (lock_clr) begin
			lock <= 1'b0;
		end
	end
	assign lock_out = lock;
	assign aperture_wide_out = wide_eff;

	// ****************************************************************
	// Track data and track clock
	// ****************************************************************

	// Per-frame presence flag; a restart counts as the frame's sync
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			seen <= 1'b0;
		end else if (realign) begin
			seen <= 1'b1;
		end else if (frame_wrap) begin
			seen <= 1'b0;
		end else if (sync_rise) begin
			seen <= 1'b1;
		end
	end
	assign dropped = frame_wrap & ~seen & ~sync_rise & ~realign;

	// Data changes at frame start while the clock is still high, one clock before it falls, so the rising clock
	// edge at mid-frame always sees a settled bit
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			track_bit_out <= 1'b0;
			trk_hist <= '0;
		end else if (frame_wrap) begin
			track_bit_out <= dropped;
			if (lock) begin
				trk_hist <= {trk_hist[TRK_HIST_W-2:0], dropped};
			end
		end
	end

	// Clock high in the second half of each field, only in lock
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			track_bit_clock_out <= 1'b0;
		end else begin
			track_bit_clock_out <= lock & ctrl[CTRL_TRK_EN] & (field_cnt >= HALF_FIELD);
		end
	end

	// ****************************************************************
	// Sample-hold release
	// ****************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < SH_CH; ch++) begin : g_sh
			// Release waits for the completed peak, one clock later
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n) begin
					sh_release_out[ch] <= 1'b0;
				end else begin
					sh_release_out[ch] <= peak_done_in[ch];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Avalon-MM slave
	// ****************************************************************
	assign bus_req = avs_read_in | avs_write_in;
	// One wait state on every access keeps read data registered
	assign avs_waitrequest_out = bus_req & ~bus_ack;
	assign wr_en = avs_write_in & bus_ack;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_mux = '0;
		unique case (avs_address_in)
			REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl;
			REG_STATUS: begin
				rd_mux[STAT_LOCK] = lock;
				rd_mux[STAT_WIDE] = wide_eff;
				rd_mux[STAT_SEL_LO +: SEL_W] = ratio_sel;
				rd_mux[STAT_FIELD_LO +: FIELD_W] = field_cnt;
			end
			REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
			REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
			REG_PHASE: rd_mux[PH_W-1:0] = phase_err_out;
			REG_TRACK: rd_mux[TRK_HIST_W-1:0] = trk_hist;
			default: rd_mux = '0;
		endcase
	end

	// Data captured in the wait cycle, presented as waitrequest falls
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_out <= '0;
		end else if (avs_read_in && !bus_ack) begin
			avs_readdata_out <= rd_mux;
		end
	end

	// Writable registers
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RST;
			irq_mask <= IRQ_RST;
		end else if (wr_en) begin
			if (avs_address_in == REG_CTRL) begin
				ctrl <= avs_writedata_in[CTRL_W-1:0];
			end
			if (avs_address_in == REG_IRQ_MASK) begin
				irq_mask <= avs_writedata_in[IRQ_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	assign irq_ev[IRQ_LOCK_GAIN] = lock_set & ~lock;
	assign irq_ev[IRQ_LOCK_LOST] = lock_clr & lock;
	assign irq_ev[IRQ_DROP] = dropped;
	assign irq_ev[IRQ_REALIGN] = realign;

	// Write one to clear; a new event in the same cycle wins over the clear
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= IRQ_RST;
		end else if (wr_en && avs_address_in == REG_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~avs_writedata_in[IRQ_W-1:0]) | irq_ev;
		end else begin
			irq_stat <= irq_stat | irq_ev;
		end
	end
	assign irq_out = |(irq_stat & irq_mask);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_frame_restart;
		@(posedge clk_in) disable iff (!rst_n)
		frame_wrap && !realign |=> frame_cnt == '0 && field_cnt == '0 && sub_cnt == '0;
	endproperty
	a_frame_restart: assert property (p_frame_restart) else $error("frame counters not restarted together");

	property p_locked_window;
		@(posedge clk_in) disable iff (!rst_n)
		sync_rise && lock && field_cnt >= WIN_LEN |=> !phase_valid_out;
	endproperty
	a_locked_window: assert property (p_locked_window) else $error("phase fired outside window in lock");

	property p_realign;
		@(posedge clk_in) disable iff (!rst_n)
		sync_rise && !lock && field_cnt >= WIN_LEN |=> frame_cnt == 7'h01 && in_norm && wide;
	endproperty
	a_realign: assert property (p_realign) else $error("unlocked stray pulse did not realign");

	property p_locked_no_realign;
		@(posedge clk_in) disable iff (!rst_n)
		lock && sync_rise && !frame_wrap |=> frame_cnt == $past(frame_cnt) + 7'h01;
	endproperty
	a_locked_no_realign: assert property (p_locked_no_realign) else $error("frame disturbed while locked");

	property p_no_pd_without_sync;
		@(posedge clk_in) disable iff (!rst_n)
		!sync_rise |=> !phase_valid_out;
	endproperty
	a_no_pd_without_sync: assert property (p_no_pd_without_sync) else $error("phase correction without sync");

	property p_lock_hold;
		@(posedge clk_in) disable iff (!rst_n)
		!sync_rise |=> $stable(lock) && $stable(in_run) && $stable(out_run);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock state moved without a pulse");

	property p_lock_gain;
		@(posedge clk_in) disable iff (!rst_n)
		sync_rise && in_norm && in_run == 3'h3 |=> lock && !wide_eff;
	endproperty
	a_lock_gain: assert property (p_lock_gain) else $error("fourth in-window pulse did not lock");

	property p_lock_loss;
		@(posedge clk_in) disable iff (!rst_n)
		sync_rise && !in_norm && out_run == 3'h3 |=> !lock;
	endproperty
	a_lock_loss: assert property (p_lock_loss) else $error("fourth outside pulse did not unlock");

	property p_track_clock;
		@(posedge clk_in) disable iff (!rst_n)
		track_bit_clock_out |-> $past(lock);
	endproperty
	a_track_clock: assert property (p_track_clock) else $error("track clock while unlocked");

	property p_track_bit;
		@(posedge clk_in) disable iff (!rst_n)
		frame_wrap && !seen && !sync_rise && !realign |=> track_bit_out;
	endproperty
	a_track_bit: assert property (p_track_bit) else $error("omitted sync not reported");

	property p_gate_hold;
		@(posedge clk_in) disable iff (!rst_n)
		sync_gate_out && sync_pulse_in |=> sync_gate_out;
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("sync gate closed early");

	property p_sh_release;
		@(posedge clk_in) disable iff (!rst_n)
		peak_done_in[0] ##1 !peak_done_in[0] |-> sh_release_out[0] ##1 !sh_release_out[0];
	endproperty
	a_sh_release: assert property (p_sh_release) else $error("sample-hold release mistimed");

endmodule // sslk_core

`default_nettype wire

// [verification/sslk_sync_src.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Sync pulse source in place of the servo preamplifier
// ****************************************************************
module sslk_sync_src (
	input wire logic clk_in,
	input wire logic en_in,
	input wire logic skip_in,
	input wire logic stray_in,
	input wire logic [7:0] period_in,
	input wire logic [7:0] pos_in,
	output logic sync_out
);
	logic [7:0] cnt = 8'h00;
	logic live = 1'b0;
	logic pulse = 1'b0;
	assign sync_out = pulse;
	// Skip is taken at the frame's last count, so one request drops one whole pulse
	always @(posedge clk_in) begin
		cnt <= (cnt >= period_in - 8'h01) ? 8'h00 : cnt + 8'h01;
		if (cnt == period_in - 8'h01) begin
			live <= en_in && !skip_in;
		end
	end
	// Four-clock pulse; the detector output is driven low between pulses
	always @(posedge clk_in) begin
		pulse <= en_in && ((live && (cnt - pos_in) < 8'h04) ||
			(stray_in && (cnt - pos_in - (period_in >> 1)) < 8'h04));
	end
endmodule // sslk_sync_src
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Bench for the servo sync lock core
// ****************************************************************
module tb;
	import sslk_pkg::*;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic sel_lo = 1'b0;
	logic sel_hi = 1'b0;
	logic sync_pulse;
	logic [SH_CH-1:0] peak_done = '0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [DATA_W-1:0] avs_writedata = '0;
	logic [DATA_W-1:0] avs_readdata_out;
	logic avs_waitrequest_out, irq_out, lock_out, aperture_wide_out, sync_gate_out, phase_valid_out;
	logic [PH_W-1:0] phase_err_out;
	logic track_bit_clock_out, track_bit_out;
	logic [SH_CH-1:0] sh_release_out;
	logic src_en = 1'b0;
	logic skip = 1'b0;
	logic stray = 1'b0;
	logic [7:0] period = 8'h20;
	logic [7:0] pos = 8'h00;
	logic sync_d = 1'b0;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	int rises = 0;
	int pv_count = 0;

	// Clock stands for the oscillator at 25 MHz
	always #20 clk_in = ~clk_in;

	sslk_core i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .frame_ratio_sel_lo_in(sel_lo),
		.frame_ratio_sel_hi_in(sel_hi), .sync_pulse_in(sync_pulse), .peak_done_in(peak_done),
		.avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
		.avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .lock_out(lock_out),
		.aperture_wide_out(aperture_wide_out), .sync_gate_out(sync_gate_out),
		.phase_valid_out(phase_valid_out), .phase_err_out(phase_err_out),
		.track_bit_clock_out(track_bit_clock_out), .track_bit_out(track_bit_out),
		.sh_release_out(sh_release_out));

	sslk_sync_src i_src (.clk_in(clk_in), .en_in(src_en), .skip_in(skip), .stray_in(stray),
		.period_in(period), .pos_in(pos), .sync_out(sync_pulse));

	// Cycle count, arrivals and phase updates; the ceiling cuts a hang short
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		sync_d <= sync_pulse;
		if (sync_pulse === 1'b1 && sync_d === 1'b0) begin
			rises <= rises + 1;
		end
		if (phase_valid_out === 1'b1) begin
			pv_count <= pv_count + 1;
		end
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			close_out();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task close_out();
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until the edge after waitrequest is seen low
	task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
		output logic [DATA_W-1:0] rd);
		@(posedge clk_in);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		@(negedge clk_in);
		while (avs_waitrequest_out !== 1'b0) @(negedge clk_in);
		@(posedge clk_in);
		rd = avs_readdata_out;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		logic [DATA_W-1:0] d;
		bus(1'b0, a, '0, d);
		cmp(d, exp);
	endtask

	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		logic [DATA_W-1:0] d;
		bus(1'b1, a, wd, d);
	endtask

	task wait_lock(input logic v);
		int n;
		n = 0;
		while (lock_out !== v && n < 4000) begin
			@(negedge clk_in);
			n++;
		end
		cmp(lock_out, v);
	endtask

	task frames(input int n);
		repeat (n * period) @(negedge clk_in);
	endtask

	// Returns at the first falling edge that sees the sync line high after a low sample
	task sync_rise();
		logic prev;
		prev = sync_pulse;
		@(negedge clk_in);
		while (!(sync_pulse === 1'b1 && prev === 1'b0)) begin
			prev = sync_pulse;
			@(negedge clk_in);
		end
	endtask

	task tck_rise();
		@(negedge clk_in);
		while (track_bit_clock_out !== 1'b0) @(negedge clk_in);
		while (track_bit_clock_out !== 1'b1) @(negedge clk_in);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [DATA_W-1:0] d;
		logic any;
		int p0;
		int t0;
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		cmp(lock_out, 1'b0);
		cmp(aperture_wide_out, 1'b1);
		rd_chk(REG_CTRL, 32'h00000008);
		rd_chk(REG_IRQ_MASK, 32'h00000000);
		rd_chk(5'h18, 32'h00000000);
		wr(5'h18, 32'hFFFFFFFF);
		wr(REG_IRQ_MASK, 32'h00000001);
		rd_chk(REG_IRQ_MASK, 32'h00000001);
		// Acquisition: a realign on the first pulse, then four in the window
		@(posedge clk_in);
		src_en <= 1'b1;
		wait_lock(1'b1);
		p0 = rises;
		bus(1'b0, REG_IRQ_STAT, '0, d);
		cmp(p0, d[IRQ_REALIGN] ? 5 : 4);
		cmp(d[IRQ_LOCK_GAIN], 1'b1);
		cmp(aperture_wide_out, 1'b0);
		cmp(irq_out, 1'b1);
		wr(REG_IRQ_STAT, 32'h0000000F);
		// The clear lands at the edge the write ends on; look once it has settled
		@(negedge clk_in);
		cmp(irq_out, 1'b0);
		// Gate holds for the whole pulse and drops after it
		sync_rise();
		repeat (2) @(negedge clk_in);
		cmp(sync_gate_out, 1'b1);
		repeat (4) @(negedge clk_in);
		cmp(sync_gate_out, 1'b0);
		// One omitted pulse while locked
		sync_rise();
		p0 = pv_count;
		@(posedge clk_in);
		skip <= 1'b1;
		frames(1);
		@(posedge clk_in);
		skip <= 1'b0;
		sync_rise();
		cmp(pv_count - p0, 1);
		cmp(lock_out, 1'b1);
		repeat (4) @(negedge clk_in);
		cmp(track_bit_out, 1'b1);
		sync_rise();
		repeat (4) @(negedge clk_in);
		cmp(track_bit_out, 1'b0);
		// Stray pulse mid-frame while locked
		wr(REG_IRQ_STAT, 32'h0000000F);
		@(posedge clk_in);
		stray <= 1'b1;
		p0 = pv_count;
		frames(3);
		@(posedge clk_in);
		stray <= 1'b0;
		cmp(pv_count - p0, 3);
		cmp(lock_out, 1'b1);
		bus(1'b0, REG_IRQ_STAT, '0, d);
		cmp(d[IRQ_REALIGN], 1'b0);
		// Sample-hold release follows peak done by one cycle
		@(posedge clk_in);
		peak_done <= 2'h1;
		@(negedge clk_in);
		cmp(sh_release_out, 2'h0);
		@(posedge clk_in);
		peak_done <= 2'h2;
		@(negedge clk_in);
		cmp(sh_release_out, 2'h1);
		@(posedge clk_in);
		peak_done <= 2'h0;
		@(negedge clk_in);
		cmp(sh_release_out, 2'h2);
		// Pulses moved out of the window: unlock, realign, relock
		@(posedge clk_in);
		pos <= 8'h0A;
		wait_lock(1'b0);
		any = 1'b0;
		repeat (3 * period) begin
			@(negedge clk_in);
			any = any | track_bit_clock_out;
		end
		cmp(any, 1'b0);
		cmp(aperture_wide_out, 1'b1);
		bus(1'b0, REG_IRQ_STAT, '0, d);
		cmp(d[IRQ_LOCK_LOST], 1'b1);
		cmp(d[IRQ_REALIGN], 1'b1);
		wait_lock(1'b1);
		// Realigned on the pulse, so each later pulse lands on count zero
		cmp(phase_err_out, 8'h00);
		// Every divide ratio, timed by the track clock while locked
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_in);
			sel_lo <= s[0];
			sel_hi <= s[1];
			period <= 8'(32 * (s + 1));
			// Let the new period settle before it sizes the wait
			@(negedge clk_in);
			frames(12);
			wait_lock(1'b1);
			tck_rise();
			t0 = cyc;
			tck_rise();
			cmp(cyc - t0, 32 * (s + 1));
			bus(1'b0, REG_STATUS, '0, d);
			cmp(d[5:4], s);
		end
		close_out();
	end
endmodule // tb
`default_nettype wire
